//--- src/zav_pkg.sv
// Purpose: Shared constants and types for the zone alarm variant logic.
// Assumes: One zone per instance, a 100 MHz clk_sys, times kept in seconds.
// Notes: All counts in cycles are derived here from the clock period.
// What this block does
// - Variant 13: group A or B actuation gives stage one, then normal sequence.
// - Variants 13 and 14: A and B together give stage two at once.
// - Variants 14 and 16: first actuation starts 40 s, then zone is reset.
// - Renewed actuation within 8 minutes after that reset gives stage one.
// - No renewed actuation within 8 minutes: false alarm, zone goes quiet.
// - Variant 15: any single actuation gives stage one at once.
// - Variants 15 and 16: two or more devices shorten the stage two wait.
// - Variant 17 in unattended mode: actuation gives stage two.
// - Variant 17 in unattended mode: zone shows disabled, normal processing off.
// - Manual call point gives stage two at once in every variant.
// - Zero-delay mode forces the three stage delays to zero.
// - Zero-delay keeps confirmation logic but makes two-stage alarms one-stage.
// - Zero-delay sets relay and signalling line output delays to zero.
// - Zero-delay leaves delays held inside line elements untouched.
// - Unattended mode maps zones to variant 1, interactive ones to 9; variant 17 keeps its number.
// - Button at access level two or more enters unattended; lamp shows it.
// - Unattended mode is entered when time hits one of four switch times.
// - Second press leaves unattended, lamp off, programmed variants come back.
// - Any fault lights the steady fault lamp and a slow interrupted tone.
// - Fault signals clear with the fault; acknowledge silences the tone early.
// - Display goes off after 10 quiet minutes; fault button steps messages.
// - Non-maskable monitoring faults are shown until they are removed.
package zav_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned PRELIM_S = 40;
    localparam int unsigned WINDOW_MIN = 8;
    localparam int unsigned DISPLAY_MIN = 10;
    localparam logic [9:0] PRELIM_SECONDS = 10'(PRELIM_S);
    localparam logic [9:0] WINDOW_SECONDS = 10'(WINDOW_MIN * 60);
    localparam logic [9:0] DISPLAY_SECONDS = 10'(DISPLAY_MIN * 60);
    localparam int unsigned SWITCH_TIMES = 4;
    localparam logic [1:0] MIN_ACCESS_LEVEL = 2'h2;
    localparam logic [2:0] PAIR_COUNT = 3'h2;

    localparam logic [4:0] VAR_IMMEDIATE = 5'h01;
    localparam logic [4:0] VAR_INTER_ONE = 5'h09;
    localparam logic [4:0] VAR_INTER_TWO = 5'h0a;
    localparam logic [4:0] VAR_GROUP_FAST = 5'h0d;
    localparam logic [4:0] VAR_PRELIM_GROUP = 5'h0e;
    localparam logic [4:0] VAR_PAIR_FAST = 5'h0f;
    localparam logic [4:0] VAR_PRELIM_PAIR = 5'h10;
    localparam logic [4:0] VAR_ZONE_OFF = 5'h11;

    typedef enum logic [2:0] {
        ZS_QUIET = 3'b000,
        ZS_PRELIM = 3'b001,
        ZS_WATCH = 3'b011,
        ZS_STAGE1 = 3'b010,
        ZS_STAGE2 = 3'b110
    } zav_zone_state_t;

    typedef struct packed {
        logic [2:0] actCount;
        logic groupA;
        logic groupB;
        logic callPoint;
        logic unattendedBtn;
        logic ackBtn;
        logic faultBtn;
    } zav_pins_t;

    typedef struct packed {
        logic [4:0] variant;
        logic [9:0] stageDelayOne;
        logic [9:0] stageDelayTwo;
        logic [9:0] stageDelayThree;
        logic [9:0] relayDelay;
        logic zeroDelay;
        logic [1:0] accessLevel;
        logic [SWITCH_TIMES-1:0] switchEn;
        logic [SWITCH_TIMES-1:0][10:0] switchTime;
    } zav_cfg_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic prelim;
        logic zoneReset;
        logic zoneDisabled;
        logic relayOutput;
        logic signallingLineOutput;
        logic elementReq;
        logic unattendedLamp;
    } zav_alarm_t;

    typedef struct packed {
        logic faultAny;
        logic newFault;
        logic nonMaskFault;
    } zav_fault_in_t;

    typedef struct packed {
        logic faultLamp;
        logic faultTone;
        logic displayOn;
        logic [2:0] msgIndex;
    } zav_fault_out_t;
endpackage : zav_pkg

//--- src/zav_sec_tick.sv
// Purpose: One-cycle pulse every second from clk_sys.
// Assumes: clk_sys at the rate given by the package.
// Notes: CYCLES is a parameter so a simulation can shorten the second.
`timescale 1ns/1ps
module zav_sec_tick
    import zav_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    output logic secTick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } zav_tick_state_t;

    zav_tick_state_t st_q;
    zav_tick_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= CYCLES - 1) begin
            st_d.cnt = 32'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign secTick = st_q.tick;

    chk_tick_period: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.tick |=> !st_q.tick)
        else $error("seconds tick lasted more than one cycle");
endmodule : zav_sec_tick

//--- src/zav_fault_ind.sv
// Purpose: Collective fault lamp, tone and fault display control.
// Assumes: Fault inputs come from logic on clk_sys; buttons already synced.
// Notes: Tone is one second on, one second off on the seconds tick.
`timescale 1ns/1ps
module zav_fault_ind
    import zav_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic secTick,
    input zav_fault_in_t faultIn,
    input wire logic ackBtn,
    input wire logic faultBtn,
    output zav_fault_out_t faultOut
);
    typedef struct packed {
        logic silenced;
        logic blink;
        logic ackPrev;
        logic btnPrev;
        logic [9:0] dispCnt;
        zav_fault_out_t out;
    } zav_fault_state_t;

    zav_fault_state_t st_q;
    zav_fault_state_t st_d;
    logic ackRise;
    logic btnRise;

    assign ackRise = ackBtn & ~st_q.ackPrev;
    assign btnRise = faultBtn & ~st_q.btnPrev;

    always_comb begin
        st_d = st_q;
        st_d.ackPrev = ackBtn;
        st_d.btnPrev = faultBtn;
        if (secTick) begin
            st_d.blink = ~st_q.blink;
        end
        // A new fault re-arms the tone even after an acknowledge
        if (!faultIn.faultAny || faultIn.newFault) begin
            st_d.silenced = 1'b0;
        end else if (ackRise) begin
            st_d.silenced = 1'b1;
        end
        if (faultIn.newFault) begin
            st_d.out.displayOn = 1'b1;
            st_d.dispCnt = 10'h0;
        end else if (btnRise) begin
            st_d.out.displayOn = 1'b1;
            st_d.dispCnt = 10'h0;
            st_d.out.msgIndex = st_q.out.msgIndex + 3'h1;
        end else if (faultIn.nonMaskFault) begin
            st_d.out.displayOn = 1'b1;
            st_d.dispCnt = 10'h0;
        end else if (st_q.out.displayOn && secTick) begin
            if (st_q.dispCnt >= DISPLAY_SECONDS - 10'h1) begin
                st_d.out.displayOn = 1'b0;
                st_d.dispCnt = 10'h0;
            end else begin
                st_d.dispCnt = st_q.dispCnt + 10'h1;
            end
        end
        st_d.out.faultLamp = faultIn.faultAny;
        st_d.out.faultTone = faultIn.faultAny & ~st_d.silenced
            & st_d.blink;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign faultOut = st_q.out;

    chk_fault_lamp: assert property (
        @(posedge clk_sys) disable iff (rst)
        faultIn.faultAny |=> faultOut.faultLamp)
        else $error("fault lamp not lit for an active fault");
    chk_tone_ack: assert property (
        @(posedge clk_sys) disable iff (rst)
        ackRise && !faultIn.newFault |=> !faultOut.faultTone)
        else $error("fault tone still on after acknowledge");
    chk_nonmask_shown: assert property (
        @(posedge clk_sys) disable iff (rst)
        faultIn.nonMaskFault |=> faultOut.displayOn)
        else $error("non-maskable fault not on display");
endmodule : zav_fault_ind

//--- src/zav_zone_alarm.sv
// Purpose: Alarm decision for one zone, unattended mode and fault signals.
// Assumes: Pin inputs are asynchronous; cfg and time come from clk_sys logic.
// Notes: Stage two follows stage one after stage delays one plus two, or after delay three alone for pairs.
`timescale 1ns/1ps
module zav_zone_alarm
    import zav_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input zav_pins_t pins,
    input zav_cfg_t cfg,
    input wire logic [10:0] timeNow,
    input wire logic alarmClear,
    input zav_fault_in_t faultIn,
    output zav_alarm_t alarm,
    output zav_fault_out_t faultOut
);
    typedef struct packed {
        zav_pins_t sync1;
        zav_pins_t sync2;
        logic [2:0] cntPrev;
        logic [2:0] cntStable;
        logic prevAny;
        logic prevBtn;
        logic [10:0] prevTime;
        logic unattended;
        zav_zone_state_t zs;
        logic [9:0] secCnt;
        logic [9:0] relayCnt;
        zav_alarm_t out;
    } zav_zone_reg_t;

    zav_zone_reg_t st_q;
    zav_zone_reg_t st_d;
    logic secTick;
    logic [4:0] effVar;
    logic anyAct;
    logic actRise;
    logic btnRise;
    logic groupCoinc;
    logic pairAct;
    logic timeHit;
    logic zoneOff;
    logic [10:0] stageWait;

    // Unattended mode swaps in the one-stage form of each variant except 17, which keeps its own
    function automatic logic [4:0] eff_variant(input logic [4:0] v,
                                               input logic away);
        logic [4:0] r;
        r = v;
        if (away && v != VAR_ZONE_OFF) begin
            if (v == VAR_INTER_ONE || v == VAR_INTER_TWO) begin
                r = VAR_INTER_ONE;
            end else begin
                r = VAR_IMMEDIATE;
            end
        end
        return r;
    endfunction : eff_variant

    function automatic logic time_match(input zav_cfg_t c,
                                        input logic [10:0] t);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < SWITCH_TIMES; i++) begin
            if (c.switchEn[i] && c.switchTime[i] == t) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : time_match

    zav_sec_tick #(
        .CYCLES(TICK_CYCLES_P)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .secTick(secTick)
    );

    zav_fault_ind u_fault (
        .clk_sys(clk_sys),
        .rst(rst),
        .secTick(secTick),
        .faultIn(faultIn),
        .ackBtn(st_q.sync2.ackBtn),
        .faultBtn(st_q.sync2.faultBtn),
        .faultOut(faultOut)
    );

    assign effVar = eff_variant(cfg.variant, st_q.unattended);
    assign anyAct = st_q.cntStable != 3'h0;
    assign actRise = anyAct & ~st_q.prevAny;
    assign btnRise = st_q.sync2.unattendedBtn & ~st_q.prevBtn;
    assign zoneOff = st_q.unattended && effVar == VAR_ZONE_OFF;
    assign groupCoinc = st_q.sync2.groupA & st_q.sync2.groupB
        & (effVar == VAR_GROUP_FAST || effVar == VAR_PRELIM_GROUP);
    assign pairAct = st_q.cntStable >= PAIR_COUNT
        & (effVar == VAR_PAIR_FAST || effVar == VAR_PRELIM_PAIR);
    // Only a change of the clock value counts, so a held match fires once
    assign timeHit = timeNow != st_q.prevTime
        && time_match(cfg, timeNow);
    // Pairs wait only the third delay instead of the first two
    assign stageWait = cfg.zeroDelay ? 11'h0 :
        pairAct ? {1'b0, cfg.stageDelayThree} :
        {1'b0, cfg.stageDelayOne} + {1'b0, cfg.stageDelayTwo};

    always_comb begin
        st_d = st_q;
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        // A multi-bit count can be torn in the synchroniser, and a torn
        // zero would look like a renewed actuation; take it once it repeats
        st_d.cntPrev = st_q.sync2.actCount;
        if (st_q.sync2.actCount == st_q.cntPrev) begin
            st_d.cntStable = st_q.sync2.actCount;
        end
        st_d.prevAny = anyAct;
        st_d.prevBtn = st_q.sync2.unattendedBtn;
        st_d.prevTime = timeNow;
        st_d.out.zoneReset = 1'b0;

        if (btnRise && cfg.accessLevel >= MIN_ACCESS_LEVEL) begin
            st_d.unattended = ~st_q.unattended;
        end else if (timeHit) begin
            st_d.unattended = 1'b1;
        end

        if (secTick) begin
            st_d.secCnt = st_q.secCnt + 10'h1;
        end

        case (st_q.zs)
            ZS_QUIET: begin
                st_d.secCnt = 10'h0;
                if (actRise) begin
                    if (zoneOff) begin
                        st_d.zs = ZS_STAGE2;
                    end else if (effVar == VAR_IMMEDIATE
                                 || effVar == VAR_INTER_ONE) begin
                        st_d.zs = ZS_STAGE2;
                    end else if (groupCoinc) begin
                        st_d.zs = ZS_STAGE2;
                    end else if (effVar == VAR_PRELIM_GROUP
                                 || effVar == VAR_PRELIM_PAIR) begin
                        st_d.zs = ZS_PRELIM;
                    end else if (cfg.zeroDelay) begin
                        st_d.zs = ZS_STAGE2;
                    end else begin
                        st_d.zs = ZS_STAGE1;
                    end
                end
            end
            ZS_PRELIM: begin
                if (groupCoinc) begin
                    st_d.zs = ZS_STAGE2;
                end else if (secTick
                             && st_q.secCnt >= PRELIM_SECONDS - 10'h1) begin
                    st_d.zs = ZS_WATCH;
                    st_d.secCnt = 10'h0;
                    st_d.out.zoneReset = 1'b1;
                end
            end
            ZS_WATCH: begin
                if (groupCoinc) begin
                    st_d.zs = ZS_STAGE2;
                end else if (actRise) begin
                    st_d.zs = cfg.zeroDelay ? ZS_STAGE2 : ZS_STAGE1;
                    st_d.secCnt = 10'h0;
                end else if (secTick
                             && st_q.secCnt >= WINDOW_SECONDS - 10'h1) begin
                    st_d.zs = ZS_QUIET;
                    st_d.secCnt = 10'h0;
                end
            end
            ZS_STAGE1: begin
                if (groupCoinc) begin
                    st_d.zs = ZS_STAGE2;
                end else if ({1'b0, st_q.secCnt} >= stageWait) begin
                    st_d.zs = ZS_STAGE2;
                end
            end
            ZS_STAGE2: begin
                if (alarmClear) begin
                    st_d.zs = ZS_QUIET;
                    st_d.secCnt = 10'h0;
                end
            end
            default: begin
                st_d.zs = ZS_QUIET;
                st_d.secCnt = 10'h0;
            end
        endcase

        // The call point wins over every variant and every state
        if (st_q.sync2.callPoint) begin
            st_d.zs = ZS_STAGE2;
        end

        if (st_d.zs == ZS_STAGE2 && st_q.zs == ZS_STAGE2) begin
            if (secTick && st_q.relayCnt != 10'h3ff) begin
                st_d.relayCnt = st_q.relayCnt + 10'h1;
            end
        end else begin
            st_d.relayCnt = 10'h0;
        end

        st_d.out.stage1 = st_d.zs == ZS_STAGE1;
        st_d.out.stage2 = st_d.zs == ZS_STAGE2;
        st_d.out.prelim = st_d.zs == ZS_PRELIM || st_d.zs == ZS_WATCH;
        st_d.out.zoneDisabled = st_d.unattended
            && eff_variant(cfg.variant, st_d.unattended)
            == VAR_ZONE_OFF;
        st_d.out.relayOutput = st_d.out.stage2
            && (cfg.zeroDelay || st_d.relayCnt >= cfg.relayDelay);
        st_d.out.signallingLineOutput = st_d.out.relayOutput;
        // Line elements apply their own delay, so they get no wait here
        st_d.out.elementReq = st_d.out.stage2;
        st_d.out.unattendedLamp = st_d.unattended;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign alarm = st_q.out;

    chk_callpoint_stage: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.sync2.callPoint |=> st_q.zs == ZS_STAGE2 && alarm.stage2)
        else $error("call point did not raise stage two");
    chk_prelim_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.zs == ZS_PRELIM && secTick && !groupCoinc
        && st_q.secCnt == PRELIM_SECONDS - 10'h1 && !st_q.sync2.callPoint
        |=> st_q.zs == ZS_WATCH && alarm.zoneReset)
        else $error("zone not reset at the end of the first wait");
    chk_window_false: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.zs == ZS_WATCH && secTick && !actRise && !groupCoinc
        && st_q.secCnt == WINDOW_SECONDS - 10'h1 && !st_q.sync2.callPoint
        |=> st_q.zs == ZS_QUIET)
        else $error("watch window did not expire to quiet");
    chk_watch_react: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.zs == ZS_WATCH && actRise
        |=> st_q.zs inside {ZS_STAGE1, ZS_STAGE2})
        else $error("renewed actuation ignored in watch window");
    chk_group_coinc: assert property (
        @(posedge clk_sys) disable iff (rst)
        groupCoinc && st_q.zs != ZS_QUIET && !alarmClear
        |=> st_q.zs == ZS_STAGE2)
        else $error("group coincidence did not raise stage two");
    // Stage one must be skipped, not merely left after a zero wait
    chk_zero_delay: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.zs == ZS_QUIET && actRise && cfg.zeroDelay && !zoneOff
        && effVar != VAR_PRELIM_GROUP && effVar != VAR_PRELIM_PAIR
        |=> st_q.zs == ZS_STAGE2)
        else $error("zero delay left a stage delay running");
    chk_relay_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        cfg.zeroDelay && $past(cfg.zeroDelay) && alarm.stage2
        |-> alarm.relayOutput && alarm.signallingLineOutput)
        else $error("zero delay left an output delay running");
    chk_away_toggle: assert property (
        @(posedge clk_sys) disable iff (rst)
        btnRise && cfg.accessLevel >= MIN_ACCESS_LEVEL
        |=> st_q.unattended != $past(st_q.unattended)
        ##1 alarm.unattendedLamp == st_q.unattended)
        else $error("unattended button did not toggle the mode");
    chk_zone_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        st_q.zs == ZS_QUIET && actRise && zoneOff
        |=> st_q.zs == ZS_STAGE2)
        else $error("disconnected zone actuation missed stage two");
    chk_quiet_count: assert property (
        @(posedge clk_sys) disable iff (rst)
        $changed(st_q.zs) && st_q.zs == ZS_QUIET |-> st_q.secCnt == 10'h0)
        else $error("zone counter not cleared on return to quiet");
endmodule : zav_zone_alarm

//--- tb/zav_devices.sv
// Purpose: Line model of the warning devices of one zone.
// Assumes: Devices latch their alarm until the panel resets the zone.
// Notes: The bench loads a new actuation set with load.
`timescale 1ns/1ps
module zav_devices (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic zoneReset,
    input wire logic load,
    input wire logic [2:0] newCount,
    input wire logic newA,
    input wire logic newB,
    output logic [2:0] actCount,
    output logic groupA,
    output logic groupB
);
    // Real detectors never drop on their own, only on a zone reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {actCount, groupA, groupB} <= 5'h00;
        end else if (zoneReset) begin
            {actCount, groupA, groupB} <= 5'h00;
        end else if (load) begin
            {actCount, groupA, groupB} <= {newCount, newA, newB};
        end
    end
endmodule : zav_devices

//--- tb/zav_zone_alarm_tb.sv
// Purpose: Self-checking bench for the zone alarm variant logic.
// Assumes: One second shortened to 10 cycles.
// Notes: Each scenario restarts the zone from reset.
`timescale 1ns/1ps
module zav_zone_alarm_tb;
    import zav_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    zav_pins_t pins;
    zav_cfg_t cfg = '0;
    logic [10:0] timeNow = 11'h000;
    zav_fault_in_t faultIn = '0;
    zav_alarm_t alarm;
    zav_fault_out_t faultOut;
    logic load = 1'b0;
    logic [2:0] newCount = 3'h0;
    logic newA = 1'b0;
    logic newB = 1'b0;
    logic callPt = 1'b0;
    logic unBtn = 1'b0;
    logic ackBtn = 1'b0;
    logic fltBtn = 1'b0;
    logic clr = 1'b0;
    logic [2:0] actCount;
    logic groupA;
    logic groupB;
    logic seen;
    int mismatches = 0;
    int samples_checked = 0;

    always #5 clk_sys = ~clk_sys;
    assign pins = {actCount, groupA, groupB, callPt, unBtn, ackBtn, fltBtn};

    zav_zone_alarm #(.TICK_CYCLES_P(10)) i_dut (.clk_sys(clk_sys),
        .rst(rst), .pins(pins), .cfg(cfg), .timeNow(timeNow),
        .alarmClear(clr), .faultIn(faultIn), .alarm(alarm),
        .faultOut(faultOut));
    zav_devices i_line (.clk_sys(clk_sys), .rst(rst),
        .zoneReset(alarm.zoneReset), .load(load), .newCount(newCount),
        .newA(newA), .newB(newB), .actCount(actCount), .groupA(groupA),
        .groupB(groupB));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic chk(string what, logic got, logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task automatic start(logic [4:0] v, logic zd);
        rst = 1'b1;
        cfg.variant = v;
        cfg.zeroDelay = zd;
        cyc(3);
        rst = 1'b0;
        cyc(2);
    endtask : start

    task automatic act(logic [2:0] n, logic a, logic b);
        newCount = n;
        newA = a;
        newB = b;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
    endtask : act

    task automatic press();
        unBtn = 1'b1;
        cyc(6);
        unBtn = 1'b0;
        cyc(6);
    endtask : press

    task automatic t_group();
        start(VAR_GROUP_FAST, 1'b0);
        act(3'h1, 1'b1, 1'b0);
        cyc(10);
        chk("stage1", alarm.stage1, 1'b1);
        chk("stage2", alarm.stage2, 1'b0);
        chk("element", alarm.elementReq, 1'b0);
        act(3'h2, 1'b1, 1'b1);
        cyc(8);
        chk("stage2", alarm.stage2, 1'b1);
        chk("relay", alarm.relayOutput, 1'b0);
    endtask : t_group

    task automatic t_prelim();
        start(VAR_PRELIM_GROUP, 1'b0);
        act(3'h1, 1'b1, 1'b0);
        cyc(10);
        chk("prelim", alarm.prelim, 1'b1);
        chk("stage1", alarm.stage1, 1'b0);
        cyc(370);
        chk("cleared", actCount == 3'h0, 1'b0);
        cyc(40);
        chk("cleared", actCount == 3'h0, 1'b1);
        act(3'h1, 1'b0, 1'b0);
        cyc(10);
        chk("stage1", alarm.stage1, 1'b1);
    endtask : t_prelim

    task automatic t_false();
        start(VAR_PRELIM_PAIR, 1'b0);
        act(3'h1, 1'b0, 1'b0);
        cyc(5120);
        chk("prelim", alarm.prelim, 1'b1);
        cyc(120);
        chk("prelim", alarm.prelim, 1'b0);
        chk("stage1", alarm.stage1, 1'b0);
    endtask : t_false

    task automatic t_pair();
        start(VAR_PAIR_FAST, 1'b0);
        act(3'h1, 1'b0, 1'b0);
        cyc(30);
        chk("stage1", alarm.stage1, 1'b1);
        chk("stage2", alarm.stage2, 1'b0);
        start(VAR_PAIR_FAST, 1'b0);
        act(3'h2, 1'b0, 1'b0);
        cyc(30);
        chk("stage2", alarm.stage2, 1'b1);
        start(VAR_PRELIM_GROUP, 1'b0);
        callPt = 1'b1;
        cyc(8);
        chk("stage2", alarm.stage2, 1'b1);
        callPt = 1'b0;
        clr = 1'b1;
        cyc(4);
        clr = 1'b0;
        cyc(1);
        chk("stage2", alarm.stage2, 1'b0);
    endtask : t_pair

    task automatic t_zero();
        start(VAR_GROUP_FAST, 1'b1);
        act(3'h1, 1'b1, 1'b0);
        cyc(8);
        chk("stage2", alarm.stage2, 1'b1);
        chk("relay", alarm.relayOutput, 1'b1);
        chk("line", alarm.signallingLineOutput, 1'b1);
        chk("element", alarm.elementReq, 1'b1);
        start(VAR_PRELIM_PAIR, 1'b1);
        act(3'h1, 1'b0, 1'b0);
        cyc(10);
        chk("prelim", alarm.prelim, 1'b1);
        chk("stage2", alarm.stage2, 1'b0);
    endtask : t_zero

    task automatic t_unatt();
        start(VAR_ZONE_OFF, 1'b0);
        cfg.accessLevel = 2'h1;
        press();
        chk("lamp", alarm.unattendedLamp, 1'b0);
        cfg.accessLevel = 2'h2;
        press();
        chk("lamp", alarm.unattendedLamp, 1'b1);
        chk("disabled", alarm.zoneDisabled, 1'b1);
        act(3'h1, 1'b0, 1'b0);
        cyc(8);
        chk("stage2", alarm.stage2, 1'b1);
        press();
        chk("lamp", alarm.unattendedLamp, 1'b0);
        chk("disabled", alarm.zoneDisabled, 1'b0);
        cfg.switchEn = 4'h4;
        cfg.switchTime[2] = 11'h123;
        timeNow = 11'h122;
        start(VAR_PRELIM_GROUP, 1'b0);
        timeNow = 11'h123;
        cyc(4);
        chk("lamp", alarm.unattendedLamp, 1'b1);
        act(3'h1, 1'b1, 1'b0);
        cyc(8);
        chk("stage2", alarm.stage2, 1'b1);
        chk("prelim", alarm.prelim, 1'b0);
        cfg.switchEn = 4'h0;
    endtask : t_unatt

    task automatic t_fault();
        start(VAR_IMMEDIATE, 1'b0);
        faultIn.faultAny = 1'b1;
        faultIn.newFault = 1'b1;
        cyc(1);
        faultIn.newFault = 1'b0;
        cyc(4);
        chk("lamp", faultOut.faultLamp, 1'b1);
        chk("display", faultOut.displayOn, 1'b1);
        seen = 1'b0;
        repeat (25) begin
            cyc(1);
            seen = seen | faultOut.faultTone;
        end
        chk("tone", seen, 1'b1);
        ackBtn = 1'b1;
        cyc(6);
        ackBtn = 1'b0;
        cyc(2);
        seen = 1'b0;
        repeat (30) begin
            cyc(1);
            seen = seen | faultOut.faultTone;
        end
        chk("tone", seen, 1'b0);
        faultIn.faultAny = 1'b0;
        cyc(4);
        chk("lamp", faultOut.faultLamp, 1'b0);
        cyc(5700);
        chk("display", faultOut.displayOn, 1'b1);
        cyc(300);
        chk("display", faultOut.displayOn, 1'b0);
        fltBtn = 1'b1;
        cyc(6);
        fltBtn = 1'b0;
        cyc(2);
        chk("display", faultOut.displayOn, 1'b1);
        chk("msg", faultOut.msgIndex == 3'h1, 1'b1);
        faultIn.nonMaskFault = 1'b1;
        cyc(6100);
        chk("display", faultOut.displayOn, 1'b1);
        faultIn.nonMaskFault = 1'b0;
    endtask : t_fault

    initial begin
        cfg.stageDelayOne = 10'h003;
        cfg.stageDelayTwo = 10'h004;
        cfg.stageDelayThree = 10'h001;
        cfg.relayDelay = 10'h002;
        cfg.accessLevel = 2'h2;
        t_group();
        t_prelim();
        t_false();
        t_pair();
        t_zero();
        t_unatt();
        t_fault();
        stop_test();
    end

    // Whole run is about 18000 cycles; this leaves a wide margin
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
endmodule : zav_zone_alarm_tb
